// *** rtl/osd_ctrl.sv ***
// Serial control, diagnostic capture and fault blanking for eight low-side outputs.
// Assumes the comparator levels and the link pins arrive asynchronously to clk_sys.
`timescale 1ns/1ps
module osd_ctrl #(
	parameter int FAULT_BLANK_DELAY = osd_pkg::FAULT_BLANK_CYCLES
) (
	input  wire logic            clk_sys,
	input  wire logic            resetn,
	input  wire logic            reset_async_n,
	input  wire logic            sel_n,
	input  wire logic            sclk,
	input  wire logic            sdi,
	output logic                 sdo_o,
	output logic                 sdo_oe,
	input  wire osd_pkg::osd_byte_t pin_high,
	output osd_pkg::osd_byte_t   out_off,
	output logic                 blanking
);
	import osd_pkg::*;

	// ==========================================================================
	// Synchronisers
	// ==========================================================================
	// Only stage two of each chain feeds logic; stage one is metastability catch.
	logic      [1:0] sel_q, sclk_q, sdi_q;
	osd_byte_t       pin_q1, pin_s;
	logic            sel_d, sclk_d;
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			sel_q  <= 2'h3;
			sclk_q <= 2'h0;
			sdi_q  <= 2'h0;
			sel_d  <= 1'h1;
			sclk_d <= 1'h0;
		end else begin
			sel_q  <= {sel_q[0], sel_n};
			sclk_q <= {sclk_q[0], sclk};
			sdi_q  <= {sdi_q[0], sdi};
			sel_d  <= sel_q[1];
			sclk_d <= sclk_q[1];
		end
	end
	always_ff @(posedge clk_sys) begin
		pin_q1 <= pin_high;
		pin_s  <= pin_q1;
	end

	// ==========================================================================
	// Edge helpers
	// ==========================================================================
	// Both detectors work on a synchronised level and its copy one cycle older.
	function automatic logic edge_up(input logic now_v, input logic was_v);
		return now_v && !was_v;
	endfunction
	function automatic logic edge_down(input logic now_v, input logic was_v);
		return !now_v && was_v;
	endfunction

	logic sel_fall, sel_rise, sck_rise, sck_fall, active;
	assign active   = !sel_q[1] && !sel_d;
	assign sel_fall = edge_down(sel_q[1], sel_d);
	assign sel_rise = edge_up(sel_q[1], sel_d);
	// Edges are ignored while select is high or toggling.
	assign sck_rise = active && edge_up(sclk_q[1], sclk_d);
	assign sck_fall = active && edge_down(sclk_q[1], sclk_d);

	// ==========================================================================
	// Shift register
	// ==========================================================================
	osd_byte_t shreg;
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			shreg <= LATCH_RESET;
			sdo_o <= 1'h0;
		end else if (sel_fall) begin
			shreg <= pin_s;
		end else if (sck_rise) begin
			sdo_o <= shreg[CHANNELS-1];
		end else if (sck_fall) begin
			shreg <= {shreg[CHANNELS-2:0], sdi_q[1]};
		end
	end
	assign sdo_oe = !sel_q[1];

	// ==========================================================================
	// Latch and blanking timer
	// ==========================================================================
	logic [BLANK_W-1:0] blank_cnt;
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			blank_cnt <= BLANK_ZERO;
		end else if (sel_rise) begin
			blank_cnt <= BLANK_W'(FAULT_BLANK_DELAY);
		end else if (blank_cnt != BLANK_ZERO) begin
			blank_cnt <= blank_cnt - BLANK_ONE;
		end
	end
	assign blanking = blank_cnt != BLANK_ZERO;

	// Asynchronous reset clears the latch at once; the loads go off without waiting for a clock.
	always_ff @(posedge clk_sys or negedge reset_async_n) begin
		if (!reset_async_n) begin
			out_off <= LATCH_RESET;
		end else if (!resetn) begin
			out_off <= LATCH_RESET;
		end else if (sel_rise) begin
			out_off <= shreg;
		end else if (!blanking) begin
			out_off <= out_off | pin_s;
		end
	end

	// ==========================================================================
	// Checks
	// ==========================================================================
	property p_oe;
		@(posedge clk_sys) disable iff (!resetn) sel_q[1] |-> !sdo_oe;
	endproperty
	a_oe: assert property (p_oe) else $error("serial output driven while deselected");
	property p_cap;
		@(posedge clk_sys) disable iff (!resetn) sel_fall |=> shreg == $past(pin_s);
	endproperty
	a_cap: assert property (p_cap) else $error("capture mismatch");
	property p_shift;
		@(posedge clk_sys) disable iff (!resetn) sck_fall |=> shreg[0] == $past(sdi_q[1]);
	endproperty
	a_shift: assert property (p_shift) else $error("input not sampled");
	property p_out;
		@(posedge clk_sys) disable iff (!resetn) sck_rise |=> sdo_o == $past(shreg[CHANNELS-1]);
	endproperty
	a_out: assert property (p_out) else $error("output bit wrong");
	property p_load;
		@(posedge clk_sys) disable iff (!resetn || !reset_async_n) sel_rise |=> out_off == $past(shreg);
	endproperty
	a_load: assert property (p_load) else $error("latch not loaded");
	property p_start;
		@(posedge clk_sys) disable iff (!resetn) sel_rise |=> blank_cnt == BLANK_W'(FAULT_BLANK_DELAY);
	endproperty
	a_start: assert property (p_start) else $error("blank timer not started");
	property p_hold;
		@(posedge clk_sys) disable iff (!resetn || !reset_async_n)
			blanking && !sel_rise |=> (out_off & ~$past(out_off)) == '0;
	endproperty
	a_hold: assert property (p_hold) else $error("latch cleared during blanking");
	property p_fault;
		@(posedge clk_sys) disable iff (!resetn || !reset_async_n)
			!blanking && !sel_rise |=> out_off == ($past(out_off) | $past(pin_s));
	endproperty
	a_fault: assert property (p_fault) else $error("fault not latched off");
	property p_rst;
		@(posedge clk_sys) !reset_async_n |-> out_off == LATCH_RESET;
	endproperty
	a_rst: assert property (p_rst) else $error("latch not cleared by reset");

	// ==========================================================================
	// Link checks
	// ==========================================================================
	property p_oe_on;
		@(posedge clk_sys) disable iff (!resetn) !sel_q[1] |-> sdo_oe;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("serial output not driven while selected");
	property p_idle;
		@(posedge clk_sys) disable iff (!resetn) sel_d && sel_q[1] |=> $stable(shreg) && $stable(sdo_o);
	endproperty
	a_idle: assert property (p_idle) else $error("shift activity while deselected");
	property p_excl;
		@(posedge clk_sys) disable iff (!resetn) !((sel_rise || sel_fall) && (sck_rise || sck_fall));
	endproperty
	a_excl: assert property (p_excl) else $error("shift clock edge taken at select edge");
	property p_sdo_hold;
		@(posedge clk_sys) disable iff (!resetn) active && !sck_rise |=> $stable(sdo_o);
	endproperty
	a_sdo_hold: assert property (p_sdo_hold) else $error("serial output moved without rising clock");
	property p_sh_hold;
		@(posedge clk_sys) disable iff (!resetn) active && !sck_fall |=> $stable(shreg);
	endproperty
	a_sh_hold: assert property (p_sh_hold) else $error("shift register moved without falling clock");
	property p_chain;
		@(posedge clk_sys) disable iff (!resetn)
			sck_fall |=> shreg[CHANNELS-1:1] == $past(shreg[CHANNELS-2:0]);
	endproperty
	a_chain: assert property (p_chain) else $error("shift register did not pass bits on");

	// ==========================================================================
	// Timer checks
	// ==========================================================================
	// The repetition only needs the timer to outlast a handful of cycles.
	property p_blank_run;
		@(posedge clk_sys) disable iff (!resetn) sel_rise |=> blanking [*8];
	endproperty
	a_blank_run: assert property (p_blank_run) else $error("blanking ended too early");
	property p_count;
		@(posedge clk_sys) disable iff (!resetn)
			blanking && !sel_rise |=> blank_cnt == $past(blank_cnt) - BLANK_ONE;
	endproperty
	a_count: assert property (p_count) else $error("blank timer did not count down");
	property p_stay_idle;
		@(posedge clk_sys) disable iff (!resetn) !blanking && !sel_rise |=> !blanking;
	endproperty
	a_stay_idle: assert property (p_stay_idle) else $error("blanking started without select");
	property p_cnt_max;
		@(posedge clk_sys) disable iff (!resetn) blank_cnt <= BLANK_W'(FAULT_BLANK_DELAY);
	endproperty
	a_cnt_max: assert property (p_cnt_max) else $error("blank timer out of range");
	property p_restart;
		@(posedge clk_sys) disable iff (!resetn)
			sel_rise && blanking |=> blank_cnt == BLANK_W'(FAULT_BLANK_DELAY);
	endproperty
	a_restart: assert property (p_restart) else $error("blank timer not restarted");

	// ==========================================================================
	// Latch checks
	// ==========================================================================
	property p_on_clear;
		@(posedge clk_sys) disable iff (!resetn || !reset_async_n)
			!blanking && !sel_rise |=> (~out_off & $past(pin_s)) == '0;
	endproperty
	a_on_clear: assert property (p_on_clear) else $error("faulty output left on");
	property p_sync_rst;
		@(posedge clk_sys) !resetn |=> out_off == LATCH_RESET && !blanking && !sdo_oe;
	endproperty
	a_sync_rst: assert property (p_sync_rst) else $error("reset did not clear state");
endmodule // osd_ctrl

// *** rtl/osd_pkg.sv ***
// Constants for the octal serial load driver control block.
// Assumes a 100 MHz system clock and a host that clocks the serial link far slower.
// Operation
// - Serial output is driven only while select is low, released otherwise.
// - Falling select loads all eight comparator states into the shift register.
// - A pin sensed high loads one, a pin sensed low loads zero.
// - Control bit zero switches the output on, one switches it off.
// - After the first rising shift clock, output seven's diagnostic bit appears.
// - Rising shift clock moves serial output; falling edge samples serial input.
// - Any number of bits passes through, allowing devices in a chain.
// - Rising select copies the shift register into the latch driving outputs.
// - Rising select starts a blanking timer of 160 microseconds.
// - While blanking runs, comparator faults never clear latch bits.
// - After blanking, on outputs sensed above threshold get their latch bit cleared.
// - Shift clock activity is ignored while select is high.
// - Asynchronous reset clears the whole latch, switching all outputs off.
// - An open, switched-off output reports low through its internal pulldown.
package osd_pkg;
	localparam int          CHANNELS           = 8;
	localparam int          SYNC_STAGES        = 2;
	localparam int          CLK_PERIOD_NS      = 10;
	localparam int          FAULT_BLANK_US     = 160;
	localparam int          FAULT_BLANK_CYCLES = (FAULT_BLANK_US * 1000) / CLK_PERIOD_NS;
	localparam int          BLANK_W            = 16;
	localparam logic [7:0]  LATCH_RESET        = 8'hFF;
	localparam logic [15:0] BLANK_ZERO         = 16'h0000;
	localparam logic [15:0] BLANK_ONE          = 16'h0001;
	typedef logic [CHANNELS-1:0] osd_byte_t;
endpackage

// *** test/osd_ctrl_bench.sv ***
// Self-checking bench for the load driver control block.
// Assumes a shortened blanking count of 300 cycles, longer than two frames apart.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
	$display("Error t=%0t got %h exp %h", $time, a, b); end end
module osd_ctrl_bench;
	import osd_pkg::*;
	logic      clk_sys, resetn, reset_async_n, sel_n, sclk, sdi, sdo_o, sdo_oe, blanking;
	localparam int BLANK = 300;
	osd_byte_t pin_high, out_off, tx, rx, open_m, short_m;
	logic      [15:0] rx16;
	int        fail_count, checked, cycles;
	// ====
	// Instances
	osd_ctrl #(.FAULT_BLANK_DELAY(BLANK)) i_dut (.clk_sys(clk_sys), .resetn(resetn), .reset_async_n(reset_async_n),
		.sel_n(sel_n), .sclk(sclk), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .pin_high(pin_high),
		.out_off(out_off), .blanking(blanking));
	osd_host i_host (.sel_n(sel_n), .sclk(sclk), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe));
	// An output that is on and sensed high is switched off; off outputs stay off.
	function automatic osd_byte_t after_blank(osd_byte_t c, osd_byte_t p);
		osd_byte_t r;
		r = c;
		for (int b = 0; b < CHANNELS; b++)
			if (!c[b] && p[b])
				r[b] = 1'b1;
		return r;
	endfunction
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic step(int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			complete_run();
		end
	end
	initial begin
		resetn = 1'b0;
		reset_async_n = 1'b1;
		pin_high = 8'h00;
		void'($urandom(32'h648C76E4));
		step(12);
		resetn = 1'b1;
		step(3);
		`CHK(out_off, 8'hFF)
		for (int n = 0; n < 10; n++) begin
			tx = (n == 0) ? 8'h00 : (n == 1) ? 8'hFF : 8'($urandom);
			pin_high = (n == 0) ? 8'hFF : (n == 1) ? 8'h00 : 8'($urandom);
			i_host.xfer(tx, rx);
			`CHK(rx, pin_high)
			step(6);
			`CHK(out_off, tx)
			`CHK(blanking, 1'b1)
			step(BLANK + 6);
			`CHK(out_off, after_blank(tx, pin_high))
			`CHK(sdo_oe, 1'b0)
			if (n == 5) begin
				reset_async_n = 1'b0;
				#2;
				`CHK(out_off, 8'hFF)
				step(1);
				reset_async_n = 1'b1;
			end
			if (n == 7) begin
				resetn = 1'b0;
				step(3);
				resetn = 1'b1;
				step(2);
				`CHK(out_off, 8'hFF)
				`CHK(blanking, 1'b0)
			end
			$display("test %0d done", n);
		end
		pin_high = 8'($urandom);
		tx = 8'($urandom);
		i_host.xfer_n(16, {tx, 8'h5A}, rx16);
		`CHK(rx16, {pin_high, tx})
		step(6);
		`CHK(out_off, 8'h5A)
		$display("chain test done");
		for (int n = 0; n < 4; n++) begin
			tx = 8'($urandom);
			open_m = 8'($urandom);
			short_m = 8'($urandom) & ~open_m;
			pin_high = (tx & ~open_m) | (~tx & short_m);
			i_host.xfer(tx, rx);
			step(100);
			i_host.xfer(tx, rx);
			`CHK(~tx & rx, ~tx & short_m)
			`CHK(tx & ~rx, tx & open_m)
			step(60);
			`CHK(out_off, tx)
			`CHK(blanking, 1'b1)
			step(BLANK + 6);
			`CHK(out_off, after_blank(tx, pin_high))
			$display("fault test %0d done", n);
		end
		complete_run();
	end
endmodule // osd_ctrl_bench

// *** test/osd_host.sv ***
// Host model: serial bus master for the load driver control block.
// Assumes the bench calls xfer from one process at a time.
`timescale 1ns/1ps
module osd_host (
	output logic sel_n,
	output logic sclk,
	output logic sdi,
	input  wire logic sdo_o,
	input  wire logic sdo_oe
);
	// ====
	// Frame
	initial begin
		sel_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
	end
	task automatic xfer_n(input int nb, input logic [15:0] tx, output logic [15:0] rx);
		rx = 16'h0000;
		sel_n = 1'b0;
		#250;
		for (int i = nb - 1; i >= 0; i--) begin
			sdi = tx[i];
			sclk = 1'b1;
			#62.5;
			rx[i] = sdo_oe ? sdo_o : 1'bz;
			sclk = 1'b0;
			#62.5;
		end
		// Inverted data after the frame so stale bits never look valid.
		sdi = ~sdi;
		#250;
		sel_n = 1'b1;
	endtask
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		logic [15:0] wide;
		xfer_n(8, {8'h00, tx}, wide);
		rx = wide[7:0];
	endtask
endmodule // osd_host
